// ### include/cdm_pkg.sv
// Package for the countdown timer settings menu.
// Assumes a single 200 MHz clock and pin-level keys.
package cdm_pkg;
  // Clock rate and timing
  localparam int CLK_HZ = 200_000_000;
  localparam int END_HOLD_S = 2; // End indication hold, seconds
  localparam int END_HOLD_CYC = END_HOLD_S * CLK_HZ;
  localparam int TONE1_S = 3; // Short alarm, seconds
  localparam int TONE2_S = 9; // Long alarm, seconds
  localparam int TONE1_CYC = TONE1_S * CLK_HZ;
  localparam int TONE2_CYC = TONE2_S * CLK_HZ;
  localparam int BEEP_HALF_CYC = CLK_HZ / 4; // Standard beep on/off half period
  // Buzzer mode codes
  localparam logic [1:0] BZ_SILENT = 2'h0;
  localparam logic [1:0] BZ_3S = 2'h1;
  localparam logic [1:0] BZ_9S = 2'h2;
  localparam logic [1:0] BZ_UNTIL_KEY = 2'h3;
  localparam logic [1:0] BZ_MAX = 2'h3;
  // Reset values of settings
  localparam logic [1:0] BZ_RST = 2'h1;
  // Full brightness code
  localparam logic [7:0] BRIGHT_FULL = 8'hFF;
  // Menu items, in visiting order
  typedef enum logic [3:0] {
    MI_IDLE = 4'h0,
    MI_BUZZER = 4'h1,
    MI_APAUSE = 4'h2,
    MI_APAUSE_SUB = 4'h3,
    MI_DIR = 4'h4,
    MI_DISP = 4'h5,
    MI_INFO = 4'h6,
    MI_CHIP = 4'h7,
    MI_FW = 4'h8,
    MI_END = 4'h9
  } cdm_item_t;
  // Key bundle after conditioning
  typedef struct packed {
    logic menu;
    logic plus;
    logic minus;
    logic ret;
  } cdm_keys_t;
  // Settings in force
  typedef struct packed {
    logic [1:0] buzz_mode;
    logic auto_pause;
    logic count_up;
    logic disp_classic;
  } cdm_cfg_t;
endpackage

// ### rtl/cdm_menu.sv
// Settings menu of a four-digit countdown timer.
// Assumes keys come straight from pins, active low, and that the
// countdown core supplies restart and alarm request strobes.
//
// Contract
// - Keys are active low, pressed when grounded
// - Plus and minus step buzzer mode
// - Buzzer modes: silent, 3s, 9s, until key
// - Plus at auto pause enters enable submenu
// - Plus counts up, minus counts down
// - Direction change applied only at restart
// - Classic mode sounds continuous tone
// - Standard mode sounds intermittent tone
// - Navigation key advances to next step
// - Return restarts current submenu from start
// - End shown, menu leaves after 2s
// - Info marker, chip number, firmware follow
// - Menu shown at full brightness
`timescale 1ns/1ps
module cdm_menu
  import cdm_pkg::*;
#(
  parameter int END_CYC = END_HOLD_CYC,
  parameter int T1_CYC = TONE1_CYC,
  parameter int T2_CYC = TONE2_CYC,
  parameter int HALF_CYC = BEEP_HALF_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic key_menu_n_in,
  input wire logic key_plus_n_in,
  input wire logic key_minus_n_in,
  input wire logic key_ret_n_in,
  input wire logic restart_in,
  input wire logic alarm_req_in,
  input wire logic [7:0] user_bright_in,
  output cdm_pkg::cdm_item_t item_out,
  output cdm_pkg::cdm_cfg_t cfg_out,
  output logic run_up_out,
  output logic menu_active_out,
  output logic [7:0] bright_out,
  output logic buzzer_out
);
  import cdm_pkg::*;

  // Two-flop synchronisers for the key pins
  logic [3:0] key_s1_q;
  logic [3:0] key_s2_q;
  logic [3:0] key_prev_q;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      key_s1_q <= 4'hF;
      key_s2_q <= 4'hF;
      key_prev_q <= 4'hF;
    end else begin
      key_s1_q <= {key_menu_n_in, key_plus_n_in, key_minus_n_in, key_ret_n_in};
      key_s2_q <= key_s1_q;
      key_prev_q <= key_s2_q;
    end
  end

  // Press edge: high to low on a grounded key
  wire logic [3:0] press_w = key_prev_q & ~key_s2_q;
  cdm_keys_t keys;
  assign keys = cdm_keys_t'(press_w);
  wire logic any_press_w = |press_w;

  // Menu state and settings
  cdm_item_t item_q, item_d;
  cdm_cfg_t cfg_q, cfg_d;
  logic run_up_q;
  logic [31:0] end_cnt_q;
  wire logic end_done_w = (item_q == MI_END) && (end_cnt_q == 32'(END_CYC - 1));

  // Next item on the navigation key, fixed order
  function automatic cdm_item_t next_item(input cdm_item_t it);
    unique case (it)
      MI_IDLE: next_item = MI_BUZZER;
      MI_BUZZER: next_item = MI_APAUSE;
      MI_APAUSE: next_item = MI_DIR;
      MI_APAUSE_SUB: next_item = MI_DIR;
      MI_DIR: next_item = MI_DISP;
      MI_DISP: next_item = MI_INFO;
      MI_INFO: next_item = MI_CHIP;
      MI_CHIP: next_item = MI_FW;
      MI_FW: next_item = MI_END;
      MI_END: next_item = MI_END;
      default: next_item = MI_IDLE;
    endcase
  endfunction

  // Menu sequencer and value editing
  always_comb begin
    item_d = item_q;
    cfg_d = cfg_q;
    if (end_done_w) begin
      item_d = MI_IDLE;
    end else if (keys.ret && item_q != MI_IDLE) begin
      item_d = (item_q == MI_APAUSE_SUB) ? MI_APAUSE : MI_BUZZER;
    end else if (keys.menu) begin
      item_d = next_item(item_q);
    end else begin
      unique case (item_q)
        MI_BUZZER: begin
          if (keys.plus && cfg_q.buzz_mode != BZ_MAX)
            cfg_d.buzz_mode = cfg_q.buzz_mode + 2'h1;
          else if (keys.minus && cfg_q.buzz_mode != BZ_SILENT)
            cfg_d.buzz_mode = cfg_q.buzz_mode - 2'h1;
        end
        MI_APAUSE: begin
          if (keys.plus) item_d = MI_APAUSE_SUB;
        end
        MI_APAUSE_SUB: begin
          if (keys.plus) cfg_d.auto_pause = 1'b1;
          else if (keys.minus) cfg_d.auto_pause = 1'b0;
        end
        MI_DIR: begin
          if (keys.plus) cfg_d.count_up = 1'b1;
          else if (keys.minus) cfg_d.count_up = 1'b0;
        end
        MI_DISP: begin
          if (keys.plus) cfg_d.disp_classic = 1'b1;
          else if (keys.minus) cfg_d.disp_classic = 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Registers of the menu
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      item_q <= MI_IDLE;
      cfg_q <= '{buzz_mode: BZ_RST, auto_pause: 1'b0, count_up: 1'b0, disp_classic: 1'b0};
      run_up_q <= 1'b0;
      end_cnt_q <= '0;
    end else begin
      item_q <= item_d;
      cfg_q <= cfg_d;
      // Direction latched only at restart so a running count is not disturbed
      if (restart_in) run_up_q <= cfg_q.count_up;
      end_cnt_q <= (item_q == MI_END && !end_done_w) ? end_cnt_q + 32'h1 : '0;
    end
  end

  // Alarm sequencer: length from buzzer mode, shape from display mode
  logic sounding_q;
  logic [31:0] tone_cnt_q;
  logic [31:0] half_cnt_q;
  logic beep_ph_q;
  wire logic [31:0] tone_len_w = (cfg_q.buzz_mode == BZ_3S) ? 32'(T1_CYC) : 32'(T2_CYC);
  wire logic timed_w = (cfg_q.buzz_mode == BZ_3S) || (cfg_q.buzz_mode == BZ_9S);
  wire logic tone_over_w = timed_w ? (tone_cnt_q >= tone_len_w - 32'h1)
                                   : any_press_w;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sounding_q <= 1'b0;
      tone_cnt_q <= '0;
    end else if (!sounding_q) begin
      sounding_q <= alarm_req_in && (cfg_q.buzz_mode != BZ_SILENT);
      tone_cnt_q <= '0;
    end else begin
      sounding_q <= !tone_over_w;
      tone_cnt_q <= tone_cnt_q + 32'h1;
    end
  end

  // Beep gating divider for the standard shape
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt_q <= '0;
      beep_ph_q <= 1'b1;
    end else if (!sounding_q) begin
      half_cnt_q <= '0;
      beep_ph_q <= 1'b1;
    end else if (half_cnt_q == 32'(HALF_CYC - 1)) begin
      half_cnt_q <= '0;
      beep_ph_q <= !beep_ph_q;
    end else begin
      half_cnt_q <= half_cnt_q + 32'h1;
    end
  end

  // Output registers
  wire logic menu_on_w = (item_d != MI_IDLE);
  // Drive follows sounding_q directly so a timed tone lasts its full count
  wire logic buzz_d = sounding_q && (cfg_q.disp_classic || beep_ph_q);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      item_out <= MI_IDLE;
      cfg_out <= '{buzz_mode: BZ_RST, auto_pause: 1'b0, count_up: 1'b0, disp_classic: 1'b0};
      run_up_out <= 1'b0;
      menu_active_out <= 1'b0;
      bright_out <= 8'h00;
      buzzer_out <= 1'b0;
    end else begin
      item_out <= item_d;
      cfg_out <= cfg_d;
      run_up_out <= restart_in ? cfg_q.count_up : run_up_q;
      menu_active_out <= menu_on_w;
      bright_out <= menu_on_w ? BRIGHT_FULL : user_bright_in;
      buzzer_out <= buzz_d;
    end
  end

  // Checks
  chk_end_leave: assert property (@(posedge mclk_in) disable iff (rst_in)
    end_done_w |=> item_q == MI_IDLE) else $error("menu did not leave after end hold");
  chk_full_bright: assert property (@(posedge mclk_in) disable iff (rst_in)
    menu_active_out |-> bright_out == BRIGHT_FULL) else $error("menu not at full brightness");
  chk_dir_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    !restart_in |=> run_up_q == $past(run_up_q)) else $error("direction changed without restart");
  chk_dir_keys: assert property (@(posedge mclk_in) disable iff (rst_in)
    item_q == MI_DIR && keys.plus && !keys.menu && !keys.ret |=> cfg_q.count_up)
    else $error("plus did not select up");
  chk_apause_enter: assert property (@(posedge mclk_in) disable iff (rst_in)
    item_q == MI_APAUSE && keys.plus && !keys.menu && !keys.ret |=> item_q == MI_APAUSE_SUB)
    else $error("plus did not enter submenu");
  chk_silent_mode: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_q.buzz_mode == BZ_SILENT && !sounding_q |=> !sounding_q) else $error("silent mode sounded");
  chk_classic_tone: assert property (@(posedge mclk_in) disable iff (rst_in)
    sounding_q && cfg_q.disp_classic |=> buzzer_out) else $error("classic tone broken");
  chk_nav_order: assert property (@(posedge mclk_in) disable iff (rst_in)
    item_q == MI_FW && keys.menu && !keys.ret && !end_done_w |=> item_q == MI_END)
    else $error("firmware not followed by end");
  chk_ret_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
    keys.ret && item_q inside {MI_DIR, MI_DISP, MI_CHIP} |=> item_q == MI_BUZZER)
    else $error("return did not restart submenu");
endmodule

// ### tb/cdm_operator.sv
// Operator model: a person pressing the four menu keys.
// Assumes pins idle high by pull-up; presses change at falling edges.
`timescale 1ns/1ps
module cdm_operator (
  input wire logic mclk_in,
  output logic [3:0] keys_n_out
);
  // Released keys float to the pull-up level
  initial begin
    keys_n_out = 4'hF;
  end
  // Grounds one key, holds it past the sync delay, then lets go
  task automatic press(input int k);
    @(negedge mclk_in);
    keys_n_out[k] = 1'b0;
    repeat (5) @(negedge mclk_in);
    keys_n_out[k] = 1'b1;
    repeat (6) @(negedge mclk_in);
  endtask
endmodule

// ### tb/cdm_menu_tb.sv
// Testbench of the settings menu, driving keys through the operator model.
// Assumes shortened timing parameters; keys: 3 menu, 2 plus, 1 minus, 0 return.
`timescale 1ns/1ps
module cdm_menu_tb;
  import cdm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic restart_in;
  logic alarm_req_in;
  logic [7:0] user_bright_in;
  logic [3:0] keys_n;
  // One named net per key pin of the design
  wire logic key_menu_n = keys_n[3];
  wire logic key_plus_n = keys_n[2];
  wire logic key_minus_n = keys_n[1];
  wire logic key_ret_n = keys_n[0];
  cdm_item_t item_out;
  cdm_cfg_t cfg_out;
  logic run_up_out;
  logic menu_active_out;
  logic [7:0] bright_out;
  logic buzzer_out;
  int n_errors = 0;
  int check_count = 0;
  int hi;
  int rises;
  int ks[8] = '{2, 2, 2, 1, 1, 1, 1, 2};
  logic [1:0] bz[8] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
  int nk[7] = '{3, 0, 3, 2, 2, 0, 3};
  cdm_item_t ni[7] = '{MI_APAUSE, MI_BUZZER, MI_APAUSE, MI_APAUSE_SUB, MI_APAUSE_SUB, MI_APAUSE, MI_DIR};
  cdm_operator cdm_operator_i (.mclk_in(mclk_in), .keys_n_out(keys_n));
  // Short counts keep the run small
  cdm_menu #(.END_CYC(20), .T1_CYC(30), .T2_CYC(90), .HALF_CYC(4)) cdm_menu_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .key_menu_n_in(key_menu_n), .key_plus_n_in(key_plus_n),
    .key_minus_n_in(key_minus_n), .key_ret_n_in(key_ret_n), .restart_in(restart_in),
    .alarm_req_in(alarm_req_in), .user_bright_in(user_bright_in), .item_out(item_out), .cfg_out(cfg_out),
    .run_up_out(run_up_out), .menu_active_out(menu_active_out), .bright_out(bright_out),
    .buzzer_out(buzzer_out));
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Fires one alarm request, then counts on-cycles and rising edges of the buzzer
  task automatic sound(input int span);
    logic prev;
    prev = 1'b0;
    hi = 0;
    rises = 0;
    @(negedge mclk_in);
    alarm_req_in = 1'b1;
    @(negedge mclk_in);
    alarm_req_in = 1'b0;
    repeat (span) begin
      @(negedge mclk_in);
      hi += int'(buzzer_out === 1'b1);
      rises += int'(buzzer_out === 1'b1 && !prev);
      prev = buzzer_out;
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected few microseconds
  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end
  initial begin
    restart_in = 1'b0;
    alarm_req_in = 1'b0;
    user_bright_in = 8'h3C;
    repeat (2) @(negedge mclk_in);
    check(8'(item_out), 8'(MI_IDLE), "reset item");
    check(8'(cfg_out.buzz_mode), 8'h1, "reset buzz");
    rst_in = 1'b0;
    @(negedge mclk_in);
    check(bright_out, 8'h3C, "idle bright");
    cdm_operator_i.press(3);
    check(8'(item_out), 8'(MI_BUZZER), "enter");
    check(bright_out, 8'hFF, "menu bright");
    for (int i = 0; i < 8; i++) begin
      cdm_operator_i.press(ks[i]);
      check(8'(cfg_out.buzz_mode), 8'(bz[i]), "buzz step");
    end
    for (int i = 0; i < 7; i++) begin
      cdm_operator_i.press(nk[i]);
      check(8'(item_out), 8'(ni[i]), "walk");
    end
    check(8'(cfg_out.auto_pause), 8'h1, "apause");
    cdm_operator_i.press(2);
    check({7'h0, cfg_out.count_up}, 8'h1, "dir up");
    check({7'h0, run_up_out}, 8'h0, "run kept");
    @(negedge mclk_in);
    restart_in = 1'b1;
    @(negedge mclk_in);
    restart_in = 1'b0;
    @(negedge mclk_in);
    check({7'h0, run_up_out}, 8'h1, "run new");
    cdm_operator_i.press(3);
    cdm_operator_i.press(2);
    check({7'h0, cfg_out.disp_classic}, 8'h1, "classic");
    for (int i = 0; i < 4; i++) begin
      cdm_operator_i.press(3);
      check(8'(item_out), 8'(MI_INFO) + 8'(i), "tail");
    end
    repeat (10) @(negedge mclk_in);
    check(8'(item_out), 8'(MI_END), "end held");
    repeat (10) @(negedge mclk_in);
    check({7'h0, menu_active_out}, 8'h0, "left");
    check(bright_out, 8'h3C, "bright back");
    user_bright_in = 8'h5A;
    @(negedge mclk_in);
    check(bright_out, 8'h5A, "bright follows");
    sound(60);
    check(8'(hi), 8'd30, "classic on");
    check(8'(rises), 8'd1, "classic steady");
    repeat (4) cdm_operator_i.press(3);
    check(bright_out, 8'hFF, "menu bright again");
    cdm_operator_i.press(1);
    check({7'h0, cfg_out.disp_classic}, 8'h0, "standard");
    sound(60);
    check({7'h0, rises > 2}, 8'h1, "standard gaps");
    cdm_operator_i.press(2);
    cdm_operator_i.press(0);
    check(8'(item_out), 8'(MI_BUZZER), "return to first");
    cdm_operator_i.press(2);
    sound(100);
    check(8'(hi), 8'd90, "long tone");
    cdm_operator_i.press(2);
    sound(40);
    check(8'(hi), 8'd40, "tone until key");
    cdm_operator_i.press(0);
    check({7'h0, buzzer_out}, 8'h0, "key stops tone");
    repeat (3) cdm_operator_i.press(1);
    check(8'(cfg_out.buzz_mode), 8'h0, "silent set");
    sound(20);
    check(8'(hi), 8'd0, "silent");
    print_verdict();
  end
endmodule
